// file: logic/ssc_sequencer.sv
`timescale 1ns/1ns
`include "ssc_defs.svh"

// How it works
// - start moves the sequencer into Run.
// - start from Idle begins at step 1 immediately.
// - start after a hold control resumes exactly where it paused.
// - start after a termination hold goes to that step's jump target.
// - hold control enters Hold and freezes the output.
// - stop goes to Idle at once; regular step keeps present values.
// - branch moves to the branch target from the present output state.
// - every step owns its own jump counter, so loops nest.
// - jump count N jumps N times, block runs N plus one times.
// - Run drives the step sync code; regular step drives all zero.
// - with phase end, step ends at first phase zero after step time.
// - while waiting for phase zero, output holds the step setting.
// - waveform changes per step only when arbitrary slots are in use.
// - jump target 1 to 255; zero means next step.
// - jump count 1 to 1023; zero means jump forever.
// - termination action beats the jump target.
// - without phase end, step ends exactly when step time elapses.
module ssc_sequencer
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // sequence controls, one-cycle pulses
  input wire ssc_ctrl_s ctrl,
  // step program port
  input wire logic progWrite,
  input wire ssc_step_t progStep,
  input wire ssc_step_s progData,
  input wire ssc_step_t lastStep,
  // output source status
  input wire logic waveIsArbitrary,
  input wire logic acPhaseZero,
  // sequence status
  output ssc_state_e state_reg,
  output ssc_step_t step_reg,
  output logic holdByTerm_reg,
  // output stage control
  output logic [`SSC_SYNC_W-1:0] syncOut_reg,
  output logic [`SSC_WAVE_W-1:0] arbitraryWaveSlot_reg,
  output logic freezeOutput_reg,
  output logic holdSetting_reg,
  output logic captureRegular_reg,
  output logic stepLoad_reg
);

  ssc_step_s stepMem [`SSC_NUM_STEPS];
  logic [`SSC_JCNT_W-1:0] jumpCnt [`SSC_NUM_STEPS];

  ssc_state_e state_next;
  ssc_step_t step_next;
  logic holdByTerm_next;
  logic load;
  logic expired;
  logic stepEnd;
  logic jumpInc;
  logic jumpReload;
  logic arbLatched_reg;
  logic timerRun;
  ssc_step_s cur;
  ssc_step_s nxt;

  // zero target means the following step number
  function automatic ssc_step_t target_of(input ssc_step_t tgt, input ssc_step_t cur);
    target_of = (tgt == `SSC_NO_STEP) ? cur + `SSC_STEP_W'(1) : tgt;
  endfunction

  // a stop in the same cycle wins over a fresh start
  function automatic logic fresh_start(input ssc_ctrl_s c, input ssc_state_e st);
    fresh_start = c.start && !c.stop && st == SSC_IDLE;
  endfunction

  assign cur = stepMem[step_reg];
  assign nxt = stepMem[step_next];

  always_ff @(posedge clk) begin
    if (progWrite) begin
      stepMem[progStep] <= progData;
    end
  end

  // step end waits for phase zero only when asked
  assign stepEnd = (state_reg == SSC_RUN) && expired
                   && (!cur.phaseEndEnable || acPhaseZero);

  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    holdByTerm_next = holdByTerm_reg;
    load = 1'b0;
    jumpInc = 1'b0;
    jumpReload = 1'b0;
    if (ctrl.stop) begin
      state_next = SSC_IDLE;
      holdByTerm_next = 1'b0;
    end else if (ctrl.hold && state_reg == SSC_RUN) begin
      state_next = SSC_HOLD;
      holdByTerm_next = 1'b0;
    end else if (ctrl.branch && state_reg == SSC_RUN && cur.branchStep != `SSC_NO_STEP) begin
      step_next = cur.branchStep;
      load = 1'b1;
    end else if (ctrl.start && state_reg != SSC_RUN) begin
      state_next = SSC_RUN;
      holdByTerm_next = 1'b0;
      if (state_reg == SSC_IDLE) begin
        step_next = `SSC_FIRST_STEP;
        load = 1'b1;
      end else if (holdByTerm_reg) begin
        step_next = target_of(cur.jumpStep, step_reg);
        load = 1'b1;
      end
    end else if (stepEnd) begin
      if (cur.termination == `SSC_TERM_HOLD) begin
        state_next = SSC_HOLD;
        holdByTerm_next = 1'b1;
      end else if (cur.termination == `SSC_TERM_STOP) begin
        state_next = SSC_IDLE;
      end else if (cur.jumpStep != `SSC_NO_STEP
                   && (cur.jumpCount == `SSC_JCNT_INFINITE
                       || jumpCnt[step_reg] < cur.jumpCount)) begin
        step_next = cur.jumpStep;
        jumpInc = (cur.jumpCount != `SSC_JCNT_INFINITE);
        load = 1'b1;
      end else begin
        jumpReload = (cur.jumpStep != `SSC_NO_STEP);
        if (step_reg >= lastStep) begin
          state_next = SSC_IDLE;
        end else begin
          step_next = step_reg + `SSC_STEP_W'(1);
          load = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= SSC_IDLE;
      step_reg <= `SSC_NO_STEP;
      holdByTerm_reg <= 1'b0;
      stepLoad_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      step_reg <= (state_next == SSC_IDLE) ? `SSC_NO_STEP : step_next;
      holdByTerm_reg <= holdByTerm_next;
      stepLoad_reg <= load && state_next == SSC_RUN;
    end
  end

  // one counter per step; cleared on every fresh start from Idle
  for (genvar g = 0; g < `SSC_NUM_STEPS; g++) begin : gen_jump
    always_ff @(posedge clk) begin
      if (!reset_n || fresh_start(ctrl, state_reg)) begin
        jumpCnt[g] <= '0;
      end else if (jumpInc && step_reg == ssc_step_t'(g)) begin
        jumpCnt[g] <= jumpCnt[g] + `SSC_JCNT_W'(1);
      end else if (jumpReload && step_reg == ssc_step_t'(g)) begin
        jumpCnt[g] <= '0;
      end
    end
  end

  // still outside Run and on the load cycle, so a new step gets whole ticks
  assign timerRun = (state_reg == SSC_RUN) && !load;

  ssc_step_timer timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(load),
    .run(timerRun),
    .loadTime(nxt.stepTime),
    .expired(expired)
  );

  // sine or square picked at start stays for the whole sequence
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      arbLatched_reg <= 1'b0;
      arbitraryWaveSlot_reg <= `SSC_WAVE_RESET;
    end else begin
      if (fresh_start(ctrl, state_reg)) begin
        arbLatched_reg <= waveIsArbitrary;
      end
      if (load && state_next == SSC_RUN
          && (state_reg == SSC_IDLE ? waveIsArbitrary : arbLatched_reg)) begin
        arbitraryWaveSlot_reg <= nxt.arbitraryWaveSlot;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      syncOut_reg <= `SSC_SYNC_FALSE;
    end else begin
      syncOut_reg <= (state_next == SSC_RUN) ? nxt.syncCode : `SSC_SYNC_FALSE;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      freezeOutput_reg <= 1'b0;
      holdSetting_reg <= 1'b0;
    end else begin
      freezeOutput_reg <= (state_next == SSC_HOLD);
      // sweep stops at the step setting once time is up
      holdSetting_reg <= (state_next == SSC_RUN) && !load && expired
                         && cur.phaseEndEnable;
    end
  end

  // regular step latches what the output shows as the sequence leaves
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      captureRegular_reg <= 1'b0;
    end else begin
      captureRegular_reg <= (state_reg != SSC_IDLE) && (state_next == SSC_IDLE);
    end
  end

endmodule

// file: inc/ssc_defs.svh
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// clock and step time base
`define SSC_CLK_PERIOD_NS 100
`define SSC_STEP_TICK_NS 100000
`define SSC_TICK_CYCLES (`SSC_STEP_TICK_NS / `SSC_CLK_PERIOD_NS)
`define SSC_TICK_W 10

// field widths
`define SSC_STEP_W 8
`define SSC_TIME_W 24
`define SSC_JCNT_W 10
`define SSC_SYNC_W 2
`define SSC_WAVE_W 4
`define SSC_NUM_STEPS 256

// special values
`define SSC_FIRST_STEP 8'h01
`define SSC_NO_STEP 8'h00
`define SSC_JCNT_INFINITE 10'h000
`define SSC_SYNC_FALSE 2'h0
`define SSC_WAVE_RESET 4'h0

// step termination encodings
`define SSC_TERM_CONTINUE 2'h0
`define SSC_TERM_HOLD 2'h1
`define SSC_TERM_STOP 2'h2

`endif

// file: inc/ssc_pkg.sv
`include "ssc_defs.svh"

package ssc_pkg;

  typedef enum logic [1:0] {
    SSC_IDLE = 2'h0,
    SSC_RUN = 2'h1,
    SSC_HOLD = 2'h3
  } ssc_state_e;

  typedef logic [`SSC_STEP_W-1:0] ssc_step_t;

  typedef struct packed {
    logic [`SSC_TIME_W-1:0] stepTime;
    logic phaseEndEnable;
    logic [1:0] termination;
    ssc_step_t jumpStep;
    logic [`SSC_JCNT_W-1:0] jumpCount;
    ssc_step_t branchStep;
    logic [`SSC_SYNC_W-1:0] syncCode;
    logic [`SSC_WAVE_W-1:0] arbitraryWaveSlot;
  } ssc_step_s;

  typedef struct packed {
    logic start;
    logic hold;
    logic stop;
    logic branch;
  } ssc_ctrl_s;

endpackage

// file: logic/ssc_step_timer.sv
`timescale 1ns/1ns
`include "ssc_defs.svh"

module ssc_step_timer
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic load,
  input wire logic run,
  input wire logic [`SSC_TIME_W-1:0] loadTime,
  // status
  output logic expired
);

  logic [`SSC_TICK_W-1:0] div_reg;
  logic [`SSC_TIME_W-1:0] remain_reg;
  logic tick;

  assign tick = run && (div_reg == `SSC_TICK_W'(`SSC_TICK_CYCLES - 1));

  // divider restarts on load so every step lasts exact whole ticks
  always_ff @(posedge clk) begin
    if (!reset_n || load) begin
      div_reg <= '0;
    end else if (run) begin
      div_reg <= tick ? '0 : div_reg + `SSC_TICK_W'(1);
    end
  end

  // frozen while run is low, so hold resumes where it stopped
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      remain_reg <= '0;
      expired <= 1'b0;
    end else if (load) begin
      remain_reg <= loadTime;
      expired <= (loadTime == '0);
    end else if (tick && !expired) begin
      remain_reg <= remain_reg - `SSC_TIME_W'(1);
      expired <= (remain_reg == `SSC_TIME_W'(1));
    end
  end

endmodule

// file: dv/ssc_sequencer_props.sv
`timescale 1ns/1ns
`include "ssc_defs.svh"
module ssc_sequencer_props
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // controls and status
  input wire ssc_ctrl_s ctrl,
  input wire ssc_state_e state_reg,
  input wire ssc_step_t step_reg,
  input wire logic holdByTerm_reg,
  input wire logic [`SSC_SYNC_W-1:0] syncOut_reg,
  input wire logic freezeOutput_reg,
  input wire logic captureRegular_reg,
  input wire logic stepLoad_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_idle_start;
    state_reg == SSC_IDLE && ctrl == 4'h8;
  endsequence
  sequence s_first_step;
    state_reg == SSC_RUN && step_reg == 8'h01 && stepLoad_reg;
  endsequence
  a_start_first_step: assert property (s_idle_start |=> s_first_step)
    else $error("start from idle missed step one");
  a_start_enters_run: assert property (state_reg != SSC_RUN && ctrl == 4'h8
    |=> state_reg == SSC_RUN) else $error("start did not run");
  a_hold_freezes: assert property (state_reg == SSC_RUN && ctrl == 4'h4
    |=> state_reg == SSC_HOLD && freezeOutput_reg) else $error("hold not taken");
  a_stop_to_idle: assert property (ctrl.stop |=> state_reg == SSC_IDLE && step_reg == 8'h00)
    else $error("stop did not idle");
  a_stop_captures: assert property (ctrl.stop && state_reg != SSC_IDLE
    |=> captureRegular_reg) else $error("no regular capture");
  a_sync_false: assert property (state_reg != SSC_RUN |-> syncOut_reg == 2'h0)
    else $error("sync not false");
  a_hold_stays: assert property (state_reg == SSC_HOLD && !ctrl.start && !ctrl.stop
    |=> state_reg == SSC_HOLD && $stable(step_reg)) else $error("hold moved");
  a_hold_resume: assert property (state_reg == SSC_HOLD && !holdByTerm_reg && ctrl == 4'h8
    |=> state_reg == SSC_RUN && $stable(step_reg)) else $error("resume moved");
  a_step_loads: assert property (state_reg == SSC_RUN && $changed(step_reg)
    |-> stepLoad_reg) else $error("step change without load");
endmodule

// file: dv/ssc_ctrl_model.sv
`timescale 1ns/1ns
module ssc_ctrl_model
  import ssc_pkg::*;
(
  // clock
  input wire logic clk,
  // controls toward the sequencer
  output ssc_ctrl_s ctrl
);
  initial ctrl = '0;
  // one-cycle pulse: 3 start, 2 hold, 1 stop, 0 branch
  task automatic pulse(input int k);
    @(posedge clk);
    ctrl <= ssc_ctrl_s'(4'h1 << k[1:0]);
    @(posedge clk);
    ctrl <= '0;
  endtask
endmodule

// file: dv/tb_step_sequence_controller.sv
`timescale 1ns/1ns
`include "ssc_defs.svh"
module tb_step_sequence_controller
  import ssc_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic progWrite = 1'b0;
  logic acPhaseZero = 1'b0;
  logic zeroGate = 1'b1, waveArb = 1'b1, freeze, holdSet, capReg;
  ssc_step_t lastStep = 8'h03;
  ssc_step_t progStep = '0;
  ssc_step_s progData = '0;
  ssc_ctrl_s ctrl;
  ssc_state_e state_reg;
  ssc_step_t step_reg;
  logic holdByTerm_reg, stepLoad_reg;
  logic [1:0] syncOut_reg;
  logic [3:0] slot;
  int failures = 0, n_checks = 0, cycles = 0, cur;
  int sy[4], jc[4], jt[4] = '{0, 0, 1, 2}, jn[4] = '{0, 0, 1, 0};
  always #50 clk = ~clk;
  // random phase zero; gated off to keep a step in its wait
  always @(posedge clk) acPhaseZero <= zeroGate & 1'($urandom_range(1));
  ssc_ctrl_model i_ssc_ctrl_model (.clk(clk), .ctrl(ctrl));
  ssc_sequencer i_ssc_sequencer (.clk(clk), .reset_n(reset_n), .ctrl(ctrl),
    .progWrite(progWrite), .progStep(progStep), .progData(progData), .lastStep(lastStep),
    .waveIsArbitrary(waveArb), .acPhaseZero(acPhaseZero), .state_reg(state_reg),
    .step_reg(step_reg), .holdByTerm_reg(holdByTerm_reg), .syncOut_reg(syncOut_reg),
    .arbitraryWaveSlot_reg(slot), .freezeOutput_reg(freeze), .holdSetting_reg(holdSet),
    .captureRegular_reg(capReg), .stepLoad_reg(stepLoad_reg));
  task automatic cmp(input logic [7:0] got, input int exp);
    n_checks++;
    if (got !== exp[7:0]) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk(input ssc_state_e st, input int s);
    @(negedge clk);
    cmp(state_reg, st);
    cmp(step_reg, s);
    cmp(syncOut_reg, (st == SSC_RUN) ? sy[s] : 0);
    cmp(freeze, int'(st == SSC_HOLD));
    if (st == SSC_RUN) cmp(slot, waveArb ? s : 3);
  endtask
  task automatic adv();
    int i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (!stepLoad_reg && state_reg == SSC_RUN && i < 3000);
  endtask
  function automatic int nxt(int s);
    if (jt[s] != 0 && jc[s] < jn[s]) begin
      jc[s]++;
      return jt[s];
    end
    jc[s] = 0;
    return s + 1;
  endfunction
  task automatic prog(input int s, input int br, input bit pe);
    ssc_step_s d;
    d = '0;
    d.stepTime = 24'h000001;
    d.phaseEndEnable = pe;
    d.termination = (s == 3) ? `SSC_TERM_HOLD : `SSC_TERM_CONTINUE;
    d.jumpStep = jt[s][7:0];
    d.jumpCount = jn[s][9:0];
    d.branchStep = br[7:0];
    sy[s] = $urandom_range(3);
    d.syncCode = sy[s][1:0];
    d.arbitraryWaveSlot = s[3:0];
    @(posedge clk);
    progWrite <= 1'b1;
    progStep <= s[7:0];
    progData <= d;
    @(posedge clk);
    progWrite <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(16));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int s = 1; s < 4; s++) prog(s, (s == 2) ? 3 : 0, 1'b0);
    i_ssc_ctrl_model.pulse(3);
    chk(SSC_RUN, 1);
    repeat (300) @(posedge clk);
    i_ssc_ctrl_model.pulse(2);
    chk(SSC_HOLD, 1);
    repeat (2000) @(posedge clk);
    chk(SSC_HOLD, 1);
    i_ssc_ctrl_model.pulse(3);
    chk(SSC_RUN, 1);
    cur = 1;
    repeat (4) begin
      cur = nxt(cur);
      adv();
      chk(SSC_RUN, cur);
    end
    adv();
    chk(SSC_HOLD, 3);
    cmp(holdByTerm_reg, 1);
    i_ssc_ctrl_model.pulse(3);
    chk(SSC_RUN, 2);
    i_ssc_ctrl_model.pulse(0);
    chk(SSC_RUN, 3);
    adv();
    chk(SSC_HOLD, 3);
    i_ssc_ctrl_model.pulse(1);
    chk(SSC_IDLE, 0);
    cmp(capReg, 1);
    prog(1, 0, 1'b1);
    lastStep <= 8'h01;
    waveArb <= 1'($urandom_range(1));
    zeroGate <= 1'b0;
    i_ssc_ctrl_model.pulse(3);
    chk(SSC_RUN, 1);
    repeat (1010) @(negedge clk);
    chk(SSC_RUN, 1);
    cmp(holdSet, 1);
    @(posedge clk) zeroGate <= 1'b1;
    adv();
    chk(SSC_IDLE, 0);
    cmp(holdSet, 0);
    complete_run();
  end
endmodule
bind ssc_sequencer ssc_sequencer_props i_ssc_sequencer_props (.clk(clk), .reset_n(reset_n),
  .ctrl(ctrl), .state_reg(state_reg), .step_reg(step_reg), .holdByTerm_reg(holdByTerm_reg),
  .syncOut_reg(syncOut_reg), .freezeOutput_reg(freezeOutput_reg),
  .captureRegular_reg(captureRegular_reg), .stepLoad_reg(stepLoad_reg));
